// >>> logic/arp_pkg.sv
// Package for the autoreload PWM timer: register map, fields and constants
package arp_pkg;
   localparam int          CNT_W         = 12;
   localparam logic [11:0] CNT_MAX       = 12'hFFF;
   localparam logic [11:0] CNT_RESET     = 12'h000;
   localparam logic [11:0] DUTY_RESET    = 12'h000;
   // Byte offsets of the registers on the AXI4-Lite bus
   localparam logic [5:0]  TCS_ADDR      = 6'h00;
   localparam logic [5:0]  CNTH_ADDR     = 6'h04;
   localparam logic [5:0]  CNTL_ADDR     = 6'h08;
   localparam logic [5:0]  RLH_ADDR      = 6'h0C;
   localparam logic [5:0]  RLL_ADDR      = 6'h10;
   localparam logic [5:0]  OCTL_ADDR     = 6'h14;
   localparam logic [5:0]  CCS_ADDR      = 6'h18;
   localparam logic [5:0]  DUTH_ADDR     = 6'h1C;
   localparam logic [5:0]  DUTL_ADDR     = 6'h20;
   localparam logic [5:0]  PWRM_ADDR     = 6'h24;
   // Field positions
   localparam int          CKSEL_LSB     = 3;
   localparam int          OVF_BIT       = 2;
   localparam int          OVERFLOW_IRQ_ENABLE_BIT     = 1;
   localparam int          COMPARE_IRQ_ENABLE_BIT     = 0;
   localparam int          POL_BIT       = 1;
   localparam int          CMPF_BIT      = 0;
   localparam int          OE_BIT        = 0;
   localparam int          GMASK_BIT     = 8;
   // Clock select codes
   localparam logic [1:0]  CK_OFF        = 2'h0;
   localparam logic [1:0]  CK_TICK       = 2'h1;
   localparam logic [1:0]  CK_CPU        = 2'h2;
   // Low power modes
   typedef enum logic [2:0] {
      PM_RUN   = 3'h0,
      PM_SLOW  = 3'h1,
      PM_WAIT  = 3'h3,
      PM_AHALT = 3'h2,
      PM_HALT  = 3'h6
   } arp_pm_type;
   localparam int          SLOW_DIV      = 32;
   localparam logic [4:0]  SLOW_LAST     = 5'h1F;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : arp_pkg

// >>> logic/arp_timer.sv
// 12-bit autoreload timer with one PWM channel and output compare
// How it works
// - PWM period is 4096 minus reload counter clocks.
// - Counter starts from zero after reset.
// - Overflow reloads counter, transfers duty to shadow, sets PWM high.
// - Counter equal to active duty drives PWM low until overflow.
// - Polarity bit inverts the PWM waveform.
// - Reload zero, duty equal reload: polarity alone gives 0% or 100%.
// - High byte write suspends compare until low byte written.
// - Compare mode uses written duty immediately.
// - PWM mode compares against the shadow duty.
// - Match sets compare flag, interrupt if enabled.
// - Duty value zero produces no compare event.
// - Every overflow copies duty into shadow, even half-written.
// - Compare mode drives no waveform; compare locked until low byte.
// - Output enable hands the pin to the push-pull PWM output.
// - Slow divides input clock by 32; wait runs; halt stops.
// - Active-halt stops unless tick clock and overflow irq enabled.
// - Wakeups: wait by both events, active-halt by overflow only.
// - Separate interrupt lines, gated by enable and global mask.
// - Clock select 00 off, 01 tick, 10 CPU, 11 reserved.
// - Overflow flag set on max-to-reload, cleared by status read.
// - Cleared overflow flag stays visible one more counter clock.
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module arp_timer
   import arp_pkg::*;
(
   // Clock and reset
   input  wire  logic        aclk,
   input  wire  logic        aresetn,
   // AXI4-Lite write
   input  wire  logic [5:0]  s_axi_awaddr,
   input  wire  logic        s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire  logic [31:0] s_axi_wdata,
   input  wire  logic [3:0]  s_axi_wstrb,
   input  wire  logic        s_axi_wvalid,
   output logic              s_axi_wready,
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire  logic        s_axi_bready,
   // AXI4-Lite read
   input  wire  logic [5:0]  s_axi_araddr,
   input  wire  logic        s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire  logic        s_axi_rready,
   // System inputs
   input  wire  logic        tick_1ms,
   // PWM pin and events
   output logic              pwm_output,
   output logic              pwm_output_oe_n,
   output logic              overflow_irq,
   output logic              compare_irq,
   output logic              wake_req
);

   // Registers
   logic [11:0] count_value_r;
   logic [11:0] reload_value_r;
   logic [11:0] duty_compare_value_r;
   logic [11:0] shadow_duty_r;
   logic [1:0]  clk_sel_r;
   logic        overflow_flag_r;
   logic        ovf_linger_r;
   logic        overflow_irq_enable_r;
   logic        compare_irq_enable_r;
   logic        output_polarity_r;
   logic        compare_match_flag_r;
   logic        pwm_pin_enable_r;
   logic        cmp_locked_r;
   logic        pwm_level_r;
   logic        pwm_out_r;
   logic [2:0]  pm_r;
   logic        gmask_r;
   logic [4:0]  slow_cnt_r;
   logic        aw_got_r;
   logic        w_got_r;
   logic [5:0]  awaddr_r;
   logic [31:0] wdata_r;
   logic        wstrb0_r;

   // Write channel: address and data taken in either order
   wire wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
   assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
   wire wr_en = wr_fire && wstrb0_r;
   wire [7:0] wbyte = wdata_r[7:0];

   function automatic logic known_addr(input logic [5:0] a);
      known_addr = (a == TCS_ADDR) || (a == CNTH_ADDR) || (a == CNTL_ADDR)
                || (a == RLH_ADDR) || (a == RLL_ADDR) || (a == OCTL_ADDR)
                || (a == CCS_ADDR) || (a == DUTH_ADDR) || (a == DUTL_ADDR)
                || (a == PWRM_ADDR);
   endfunction : known_addr

   wire wr_tcs  = wr_en && awaddr_r == TCS_ADDR;
   wire wr_rlh  = wr_en && awaddr_r == RLH_ADDR;
   wire wr_rll  = wr_en && awaddr_r == RLL_ADDR;
   wire wr_octl = wr_en && awaddr_r == OCTL_ADDR;
   wire wr_ccs  = wr_en && awaddr_r == CCS_ADDR;
   wire wr_duth = wr_en && awaddr_r == DUTH_ADDR;
   wire wr_dutl = wr_en && awaddr_r == DUTL_ADDR;
   wire wr_pwrm = wr_en && awaddr_r == PWRM_ADDR;

   // Read channel; status reads clear flags
   wire rd_fire = s_axi_arvalid && s_axi_arready;
   assign s_axi_arready = !s_axi_rvalid;
   wire rd_tcs = rd_fire && s_axi_araddr == TCS_ADDR;
   wire rd_ccs = rd_fire && s_axi_araddr == CCS_ADDR;

   // Counter clock enable
   wire pm_slow  = pm_r == PM_SLOW;
   wire pm_ahalt = pm_r == PM_AHALT;
   wire pm_halt  = pm_r == PM_HALT;
   wire slow_ok  = !pm_slow || slow_cnt_r == SLOW_LAST;
   wire ahalt_run = clk_sel_r == CK_TICK && overflow_irq_enable_r;
   wire mode_run = !pm_halt && (!pm_ahalt || ahalt_run);
   wire src_tick = (clk_sel_r == CK_TICK && tick_1ms)
                || (clk_sel_r == CK_CPU);
   wire cnt_en   = src_tick && slow_ok && mode_run;

   // Overflow and compare
   wire at_max   = count_value_r == CNT_MAX;
   wire ovf_ev   = cnt_en && at_max;
   wire [11:0] cmp_ref = pwm_pin_enable_r ? shadow_duty_r
                                          : duty_compare_value_r;
   wire cmp_ev   = cnt_en && !at_max && !cmp_locked_r && cmp_ref != DUTY_RESET
                && count_value_r + 12'h001 == cmp_ref;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         slow_cnt_r <= 5'h00;
      else if (pm_slow)
         slow_cnt_r <= slow_cnt_r + 5'h01;
      else
         slow_cnt_r <= 5'h00;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         count_value_r <= CNT_RESET;
      else if (ovf_ev)
         count_value_r <= reload_value_r;
      else if (cnt_en)
         count_value_r <= count_value_r + 12'h001;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         shadow_duty_r <= DUTY_RESET;
      else if (ovf_ev)
         shadow_duty_r <= duty_compare_value_r;
   end

   // PWM level: high at overflow, low at match
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pwm_level_r <= 1'b0;
      else if (ovf_ev)
         pwm_level_r <= 1'b1;
      else if (cmp_ev)
         pwm_level_r <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pwm_out_r <= 1'b0;
      else
         pwm_out_r <= pwm_pin_enable_r & (pwm_level_r ^ output_polarity_r);
   end
   assign pwm_output      = pwm_out_r;
   assign pwm_output_oe_n = !pwm_pin_enable_r;

   // Flags: set wins over read-clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         overflow_flag_r <= 1'b0;
         ovf_linger_r    <= 1'b0;
      end
      else
      begin
         if (ovf_ev)
            overflow_flag_r <= 1'b1;
         else if (rd_tcs)
            overflow_flag_r <= 1'b0;
         if (rd_tcs && overflow_flag_r && !ovf_ev)
            ovf_linger_r <= 1'b1;
         else if (cnt_en || ovf_ev)
            ovf_linger_r <= 1'b0;
      end
   end
   wire ovf_seen = overflow_flag_r || ovf_linger_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         compare_match_flag_r <= 1'b0;
      else if (cmp_ev)
         compare_match_flag_r <= 1'b1;
      else if (rd_ccs)
         compare_match_flag_r <= 1'b0;
   end

   // Software registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         clk_sel_r             <= CK_OFF;
         overflow_irq_enable_r <= 1'b0;
         compare_irq_enable_r  <= 1'b0;
         reload_value_r        <= CNT_RESET;
         pwm_pin_enable_r      <= 1'b0;
         output_polarity_r     <= 1'b0;
         duty_compare_value_r  <= DUTY_RESET;
         cmp_locked_r          <= 1'b0;
         pm_r                  <= PM_RUN;
         gmask_r               <= 1'b0;
      end
      else
      begin
         if (wr_tcs)
         begin
            clk_sel_r             <= wbyte[CKSEL_LSB+1:CKSEL_LSB];
            overflow_irq_enable_r <= wbyte[OVERFLOW_IRQ_ENABLE_BIT];
            compare_irq_enable_r  <= wbyte[COMPARE_IRQ_ENABLE_BIT];
         end
         if (wr_rlh)
            reload_value_r[11:8] <= wbyte[3:0];
         if (wr_rll)
            reload_value_r[7:0] <= wbyte;
         if (wr_octl)
            pwm_pin_enable_r <= wbyte[OE_BIT];
         if (wr_ccs)
            output_polarity_r <= wbyte[POL_BIT];
         if (wr_duth)
         begin
            duty_compare_value_r[11:8] <= wbyte[3:0];
            cmp_locked_r               <= 1'b1;
         end
         if (wr_dutl)
         begin
            duty_compare_value_r[7:0] <= wbyte;
            cmp_locked_r              <= 1'b0;
         end
         if (wr_pwrm)
         begin
            pm_r    <= wbyte[2:0];
            gmask_r <= wdata_r[GMASK_BIT];
         end
      end
   end

   // Interrupts and wakeup
   assign overflow_irq = overflow_flag_r && overflow_irq_enable_r && !gmask_r;
   assign compare_irq  = compare_match_flag_r && compare_irq_enable_r && !gmask_r;
   assign wake_req = (pm_r == PM_WAIT && (overflow_irq || compare_irq))
                  || (pm_ahalt && overflow_irq && clk_sel_r == CK_TICK);

   // Bus handshake state
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_r <= 1'b0;
         w_got_r  <= 1'b0;
         awaddr_r <= 6'h00;
         wdata_r  <= 32'h00000000;
         wstrb0_r <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got_r  <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb0_r <= s_axi_wstrb[0];
         end
         if (wr_fire)
         begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= known_addr(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = 32'h00000000;
      case (s_axi_araddr)
         TCS_ADDR:  rd_mux[4:0] = {clk_sel_r, ovf_seen, overflow_irq_enable_r,
                                   compare_irq_enable_r};
         CNTH_ADDR: rd_mux[3:0] = count_value_r[11:8];
         CNTL_ADDR: rd_mux[7:0] = count_value_r[7:0];
         RLH_ADDR:  rd_mux[3:0] = reload_value_r[11:8];
         RLL_ADDR:  rd_mux[7:0] = reload_value_r[7:0];
         OCTL_ADDR: rd_mux[0]   = pwm_pin_enable_r;
         CCS_ADDR:  rd_mux[1:0] = {output_polarity_r, compare_match_flag_r};
         DUTH_ADDR: rd_mux[3:0] = duty_compare_value_r[11:8];
         DUTL_ADDR: rd_mux[7:0] = duty_compare_value_r[7:0];
         PWRM_ADDR: rd_mux[8:0] = {gmask_r, 5'h00, pm_r};
         default:   rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (rd_fire)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= known_addr(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // Checks
   reload_ovf_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ovf_ev |=> count_value_r == $past(reload_value_r))
      else $error("counter did not reload on overflow");
   pwm_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ovf_ev |=> pwm_level_r)
      else $error("pwm not set high at overflow");
   shadow_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ovf_ev |=> shadow_duty_r == $past(duty_compare_value_r))
      else $error("shadow not loaded");
   // Pin lags the level by one clock, so it uses that clock's enable and polarity
   pwm_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cmp_ev |=> !pwm_level_r
         ##1 pwm_out_r == ($past(pwm_pin_enable_r) && $past(output_polarity_r)))
      else $error("pwm not low after match");
   cmp_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cmp_locked_r |-> !cmp_ev)
      else $error("compare while locked");
   zero_duty_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cmp_ref == DUTY_RESET |-> !cmp_ev)
      else $error("compare on zero duty");
   cmpf_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cmp_ev |=> compare_match_flag_r)
      else $error("compare flag not set");
   clk_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_sel_r == CK_OFF |=> $stable(count_value_r))
      else $error("counter moved while off");
   halt_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
      pm_halt |-> !cnt_en)
      else $error("counter ran in halt");
   ovf_linger_a: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_tcs && overflow_flag_r |=> ovf_seen)
      else $error("overflow flag vanished early");
   oe_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !pwm_pin_enable_r |-> pwm_output_oe_n)
      else $error("pin driven while disabled");

endmodule : arp_timer
`default_nettype wire

// >>> tb/arp_load_model.sv
// External load on the PWM pin: resolves the pin level and measures the waveform
`timescale 1ns/1ps
`default_nettype none
module arp_load_model
(
   // Clock
   input  wire  logic        aclk,
   // Pin drive from the timer
   input  wire  logic        pwm_output,
   input  wire  logic        pwm_output_oe_n,
   // Measurements
   output logic              pin_level,
   output logic [15:0]       high_len,
   output logic [15:0]       period_len
);
   logic [15:0] hi_run  = 16'h0000;
   logic [15:0] per_run = 16'h0000;
   logic        last_r  = 1'b0;

   // Weak pull-down holds the pin low once the timer releases it
   assign pin_level = pwm_output_oe_n ? 1'b0 : pwm_output;

   initial high_len = 16'h0000;
   initial period_len = 16'h0000;

   // Rising edge to rising edge gives the period, high run gives the pulse width
   always @(posedge aclk)
   begin
      last_r <= pin_level;
      if (pin_level && !last_r)
      begin
         period_len <= per_run;
         per_run    <= 16'h0001;
         hi_run     <= 16'h0001;
      end
      else
      begin
         per_run <= per_run + 16'h0001;
         if (pin_level)
            hi_run <= hi_run + 16'h0001;
      end
      if (!pin_level && last_r)
         high_len <= hi_run;
   end
endmodule : arp_load_model
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the autoreload PWM timer over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module testbench
   import arp_pkg::*;
;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'h0;
   logic        tick = 1'b0;
   wire         awready, wready, bvalid, arready, rvalid;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire         pwm_o, oe_n, ovf_irq, cmp_irq, wake, pin;
   wire  [15:0] high_len, period_len;
   int          failures = 0;
   int          samples_checked = 0;
   logic [31:0] d;
   logic [1:0]  r;
   logic [11:0] c0, c1;

   always #25 aclk = ~aclk;

   arp_timer i_arp_timer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .tick_1ms(tick), .pwm_output(pwm_o),
      .pwm_output_oe_n(oe_n), .overflow_irq(ovf_irq), .compare_irq(cmp_irq),
      .wake_req(wake));
   arp_load_model i_arp_load_model (.aclk(aclk), .pwm_output(pwm_o),
      .pwm_output_oe_n(oe_n), .pin_level(pin), .high_len(high_len),
      .period_len(period_len));

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict

   // Master holds each channel until its own handshake edge
   task automatic wr(input logic [5:0] a, input logic [31:0] v, output logic [1:0] resp);
      int n;
      @(posedge aclk);
      awaddr <= a; wdata <= v; wstrb <= 4'hF;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready)
         begin
            resp = bresp;
            bready <= 1'b0;
            break;
         end
      end
      if (n == 100) chk("write timeout", 32'h1, 32'h0);
   endtask : wr

   task automatic rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] resp);
      int n;
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready)
         begin
            v = rdata;
            resp = rresp;
            rready <= 1'b0;
            break;
         end
      end
      if (n == 100) chk("read timeout", 32'h1, 32'h0);
   endtask : rd

   task automatic wrb(input logic [5:0] a, input logic [31:0] v);
      logic [1:0] resp;
      wr(a, v, resp);
      chk("bresp", {30'h0, RESP_OKAY}, {30'h0, resp});
   endtask : wrb

   task automatic get_count(output logic [11:0] cv);
      logic [31:0] h, l;
      rd(CNTH_ADDR, h, r);
      rd(CNTL_ADDR, l, r);
      cv = {h[3:0], l[7:0]};
   endtask : get_count

   task automatic cycles(input int n);
      repeat (n) @(posedge aclk);
   endtask : cycles

   // One-cycle tick pulses, spaced apart
   task automatic ticks(input int n);
      repeat (n)
      begin
         @(posedge aclk);
         tick <= 1'b1;
         @(posedge aclk);
         tick <= 1'b0;
         cycles(2);
      end
   endtask : ticks

   initial
   begin
      #(50 * 40000);
      failures++;
      print_verdict();
   end

   initial
   begin
      cycles(20);
      aresetn <= 1'b1;
      for (int i = 0; i < 10; i++)
      begin
         rd(6'(i * 4), d, r);
         chk("reset value", 32'h0, d);
      end
      chk("pin released", 32'h1, {31'h0, oe_n});
      // PWM: period 4096-0xF00, high from reload up to duty
      wrb(RLH_ADDR, 32'h0F); wrb(RLL_ADDR, 32'h00);
      wrb(DUTH_ADDR, 32'h0F); wrb(DUTL_ADDR, 32'h80);
      wrb(OCTL_ADDR, 32'h01); wrb(TCS_ADDR, 32'h10);
      // First overflow comes only after a full count up from zero
      cycles(4800);
      chk("pin driven", 32'h0, {31'h0, oe_n});
      chk("period", 32'd256, {16'h0, period_len});
      chk("high time", 32'd128, {16'h0, high_len});
      // Duty update lands just after an overflow
      @(posedge pin);
      wrb(CCS_ADDR, 32'h02); wrb(DUTH_ADDR, 32'h0F); wrb(DUTL_ADDR, 32'h40);
      cycles(800);
      chk("inverted high", 32'd192, {16'h0, high_len});
      rd(TCS_ADDR, d, r);
      chk("overflow flag", 32'h14, d & 32'h1C);
      wrb(TCS_ADDR, 32'h12);
      cycles(300);
      chk("overflow irq", 32'h1, {31'h0, ovf_irq});
      wrb(PWRM_ADDR, 32'h3);
      chk("wake in wait", 32'h1, {31'h0, wake});
      wrb(PWRM_ADDR, 32'h6);
      chk("no wake in halt", 32'h0, {31'h0, wake});
      get_count(c0); cycles(100); get_count(c1);
      chk("halt holds count", {20'h0, c0}, {20'h0, c1});
      wrb(PWRM_ADDR, 32'h100);
      chk("masked irq", 32'h0, {31'h0, ovf_irq});
      wrb(PWRM_ADDR, 32'h0);
      // Output compare with the written duty, locked between the byte writes
      wrb(TCS_ADDR, 32'h11); wrb(OCTL_ADDR, 32'h00);
      wrb(DUTH_ADDR, 32'h0F);
      rd(CCS_ADDR, d, r);
      cycles(600);
      rd(CCS_ADDR, d, r);
      chk("compare locked", 32'h0, d & 32'h1);
      wrb(DUTL_ADDR, 32'hA0);
      cycles(300);
      chk("compare irq", 32'h1, {31'h0, cmp_irq});
      chk("no waveform", 32'h0, {30'h0, oe_n, pwm_o} ^ 32'h2);
      rd(CCS_ADDR, d, r);
      chk("compare flag", 32'h1, d & 32'h1);
      // Duty zero never matches, even when the counter passes zero
      wrb(RLH_ADDR, 32'h00); wrb(DUTH_ADDR, 32'h00); wrb(DUTL_ADDR, 32'h00);
      rd(CCS_ADDR, d, r);
      cycles(4300);
      rd(CCS_ADDR, d, r);
      chk("zero duty", 32'h0, d & 32'h1);
      // Duty equal to a zero reload: polarity alone picks 0% or 100%
      wrb(OCTL_ADDR, 32'h01);
      cycles(300);
      chk("steady low", 32'h0, {31'h0, pin});
      wrb(CCS_ADDR, 32'h00);
      cycles(300);
      chk("steady high", 32'h1, {31'h0, pin});
      wrb(OCTL_ADDR, 32'h00);
      // Clock select off, then the tick as counter clock
      wrb(TCS_ADDR, 32'h00);
      get_count(c0); cycles(100); get_count(c1);
      chk("clock off holds", {20'h0, c0}, {20'h0, c1});
      wrb(TCS_ADDR, 32'h08);
      get_count(c0);
      ticks(5);
      get_count(c1);
      chk("tick count", {20'h0, c0 + 12'h005}, {20'h0, c1});
      // Active-halt runs only on the tick with the overflow interrupt enabled
      wrb(PWRM_ADDR, 32'h2);
      ticks(3);
      get_count(c0);
      chk("active-halt stops", {20'h0, c1}, {20'h0, c0});
      wrb(TCS_ADDR, 32'h0A);
      ticks(3);
      get_count(c0);
      chk("active-halt runs", {20'h0, c1 + 12'h003}, {20'h0, c0});
      // Slow mode: one count in 32 clocks, one more allowed for the divider phase
      wrb(PWRM_ADDR, 32'h1);
      wrb(TCS_ADDR, 32'h10);
      cycles(3200);
      wrb(TCS_ADDR, 32'h00);
      get_count(c1);
      chk("slow divide", 32'h1, {31'h0, (c1 - c0 == 12'd100) || (c1 - c0 == 12'd101)});
      wrb(PWRM_ADDR, 32'h0);
      // Reset in mid-run clears the count and the control bits
      aresetn <= 1'b0;
      cycles(2);
      aresetn <= 1'b1;
      get_count(c0);
      chk("count after reset", 32'h0, {20'h0, c0});
      rd(TCS_ADDR, d, r);
      chk("control after reset", 32'h0, d);
      wr(6'h3C, 32'h1, r);
      chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
      rd(6'h3C, d, r);
      chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, r});
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
